/* wakeup_amp_props.sv */
// checker for the wake-up timer register bus and measurement requests
`timescale 1ns/1ps
`default_nettype none
module wakeup_amp_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic amp_meas_req,
  input wire logic amp_meas_done,
  input wire logic phase_meas_req,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a set default in mid-wait would leave this high; the bench never aborts a wait
  logic wait_r;
  always @(posedge aclk) begin
    if (!aresetn) wait_r <= 1'b0;
    else if (amp_meas_req) wait_r <= 1'b1;
    else if (amp_meas_done) wait_r <= 1'b0;
  end
  amp_pulse_a: assert property (amp_meas_req |=> !amp_meas_req)
    else $error("amp request too long");
  amp_single_a: assert property (amp_meas_req |-> !wait_r)
    else $error("amp request while waiting");
  phase_pulse_a: assert property (phase_meas_req |=> !phase_meas_req)
    else $error("phase request too long");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  read_turn_a: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !irq && !amp_meas_req && !phase_meas_req)
    else $error("output active after reset");
  cover property (amp_meas_req);
  cover property (phase_meas_req);
  cover property ($rose(irq));
endmodule
bind wakeup_amp_timer wakeup_amp_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .amp_meas_req(amp_meas_req), .amp_meas_done(amp_meas_done), .phase_meas_req(phase_meas_req), .irq(irq));
`default_nettype wire

/* wakeup_amp_regs.vh */
// register map, field positions, reset values and timing constants of the wake-up timer block
// Summary of operation
// - range bit selects base step, 0 gives 100 ms, 1 gives 10 ms.
// - wake-up period is (timeout code plus one) times base step.
// - timeout interrupt bit raises an interrupt at every timer expiry.
// - amplitude bit measures at expiry, interrupts if difference from reference exceeds threshold.
// - phase bit starts a phase measurement at expiry, its interrupt is forwarded.
// - amplitude threshold is upper nibble of amplitude configuration byte.
// - include-trigger bit decides if an interrupting result updates the average.
// - average weight code 00,01,10,11 selects 4, 8, 16, 32.
// - reference select 0 uses software reference, 1 uses auto-average.
// - software amplitude reference is an 8-bit read-write byte.
// - current amplitude auto-average readable in a read-only byte.
// - latest amplitude result readable in its own read-only byte.
// - control, configuration and reference bytes clear on reset and Set Default.
// - both amplitude result bytes clear on reset and Set Default.
// - wake-up timer control byte bits 7 to 1 are read-write at its own address, bit 0 always reads 0.
`ifndef WAKEUP_AMP_REGS_VH
`define WAKEUP_AMP_REGS_VH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IDX_WAKEUP_CTRL 8'h31
`define IDX_AMP_CFG 8'h32
`define IDX_AMP_REF 8'h33
`define IDX_AMP_AVG 8'h34
`define IDX_AMP_RESULT 8'h35
`define IDX_IRQ_STATUS 8'h40
`define IDX_IRQ_MASK 8'h41
`define IDX_COMMAND 8'h42

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_RANGE_BIT 7
`define CTRL_CODE_MSB 6
`define CTRL_CODE_LSB 4
`define CTRL_TIMEOUT_IRQ_BIT 3
`define CTRL_AMP_BIT 2
`define CTRL_PHASE_BIT 1
`define CTRL_WRITE_MASK 8'hFE
`define CFG_THR_MSB 7
`define CFG_THR_LSB 4
`define CFG_INCLUDE_BIT 3
`define CFG_WEIGHT_MSB 2
`define CFG_WEIGHT_LSB 1
`define CFG_REF_SEL_BIT 0
`define STAT_TIMEOUT_BIT 0
`define STAT_AMP_BIT 1
`define STAT_PHASE_BIT 2
`define CMD_SET_DEFAULT_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_STAT 3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_KHZ 25000
`define STEP_LONG_MS 100
`define STEP_SHORT_MS 10
`define STEP_LONG_CYC (`STEP_LONG_MS * `CLK_KHZ)
`define STEP_SHORT_CYC (`STEP_SHORT_MS * `CLK_KHZ)

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* wakeup_amp_timer.v */
// wake-up timer with amplitude wake-up detection, AXI4-Lite register slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_amp_regs.vh"

module wakeup_amp_timer #(
  parameter STEP_LONG_CYC = `STEP_LONG_CYC,
  parameter STEP_SHORT_CYC = `STEP_SHORT_CYC,
  parameter ADDR_W = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg amp_meas_req,
  input wire amp_meas_done,
  input wire [7:0] amp_meas_result,
  output reg phase_meas_req,
  input wire phase_wake_event,
  output reg irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // maps a byte address to a register index, 8'hFF when unaligned or out of range
  function [7:0] reg_index;
    input [ADDR_W-1:0] addr;
    begin
      if (addr[1:0] != 2'h0 || addr[ADDR_W-1:10] != 0) begin
        reg_index = 8'hFF;
      end else begin
        reg_index = addr[9:2];
      end
    end
  endfunction

  function mapped;
    input [7:0] idx;
    begin
      mapped = (idx == `IDX_WAKEUP_CTRL) || (idx == `IDX_AMP_CFG) || (idx == `IDX_AMP_REF) ||
               (idx == `IDX_AMP_AVG) || (idx == `IDX_AMP_RESULT) || (idx == `IDX_IRQ_STATUS) ||
               (idx == `IDX_IRQ_MASK) || (idx == `IDX_COMMAND);
    end
  endfunction

  localparam [31:0] LONG_CYC = STEP_LONG_CYC;
  localparam [31:0] SHORT_CYC = STEP_SHORT_CYC;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_r;
  reg [7:0] cfg_r;
  reg [7:0] ref_r;
  reg [7:0] avg_r;
  reg [7:0] result_r;
  reg [2:0] status_r;
  reg [2:0] mask_r;
  reg [31:0] step_cnt_r;
  reg [2:0] mult_cnt_r;
  reg [1:0] state_r;
  reg [ADDR_W-1:0] awaddr_r;
  reg aw_have_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_have_r;

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  wire [7:0] wr_idx = reg_index(awaddr_r);
  wire wr_lane0 = wr_go && wstrb_r[0];
  wire ctrl_wr = wr_lane0 && (wr_idx == `IDX_WAKEUP_CTRL);
  wire set_default = wr_lane0 && (wr_idx == `IDX_COMMAND) && wdata_r[`CMD_SET_DEFAULT_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= {ADDR_W{1'b0}};
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      // ready is offered only while the holding slot is empty
      s_axi_awready <= !aw_have_r && !aw_take;
      s_axi_wready <= !w_have_r && !w_take;
      if (aw_take) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || set_default) begin
      ctrl_r <= `RST_BYTE;
      cfg_r <= `RST_BYTE;
      ref_r <= `RST_BYTE;
      mask_r <= `RST_STAT;
    end else if (wr_lane0) begin
      case (wr_idx)
        `IDX_WAKEUP_CTRL: ctrl_r <= wdata_r[7:0] & `CTRL_WRITE_MASK;
        `IDX_AMP_CFG: cfg_r <= wdata_r[7:0];
        `IDX_AMP_REF: ref_r <= wdata_r[7:0];
        `IDX_IRQ_MASK: mask_r <= wdata_r[2:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wake-up timer
  // ----------------------------------------------------------------
  wire timer_on = ctrl_r[`CTRL_TIMEOUT_IRQ_BIT] || ctrl_r[`CTRL_AMP_BIT] || ctrl_r[`CTRL_PHASE_BIT];
  wire [31:0] step_len = ctrl_r[`CTRL_RANGE_BIT] ? SHORT_CYC : LONG_CYC;
  wire step_end = (step_cnt_r == step_len - 32'h1);
  wire expiry = timer_on && step_end && (mult_cnt_r == ctrl_r[`CTRL_CODE_MSB:`CTRL_CODE_LSB]);

  // a control write restarts the period so a new code takes effect from a clean start
  always @(posedge aclk) begin
    if (!aresetn || set_default || ctrl_wr || !timer_on) begin
      step_cnt_r <= 32'h0;
      mult_cnt_r <= 3'h0;
    end else if (step_end) begin
      step_cnt_r <= 32'h0;
      mult_cnt_r <= expiry ? 3'h0 : mult_cnt_r + 3'h1;
    end else begin
      step_cnt_r <= step_cnt_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // amplitude measurement and auto-average
  // ----------------------------------------------------------------
  wire [7:0] amp_ref = cfg_r[`CFG_REF_SEL_BIT] ? avg_r : ref_r;
  wire [7:0] amp_diff = (amp_meas_result > amp_ref) ? amp_meas_result - amp_ref : amp_ref - amp_meas_result;
  wire amp_hit = amp_diff > {4'h0, cfg_r[`CFG_THR_MSB:`CFG_THR_LSB]};
  wire [8:0] avg_delta = {1'b0, amp_meas_result} - {1'b0, avg_r};
  wire [2:0] avg_shift = {1'b0, cfg_r[`CFG_WEIGHT_MSB:`CFG_WEIGHT_LSB]} + 3'h2;
  wire [8:0] avg_step = $signed(avg_delta) >>> avg_shift;
  wire [8:0] avg_sum = {1'b0, avg_r} + avg_step;
  wire meas_in = (state_r == ST_WAIT) && amp_meas_done;
  wire avg_upd = meas_in && (!amp_hit || cfg_r[`CFG_INCLUDE_BIT]);
  wire amp_event = meas_in && amp_hit;

  always @(posedge aclk) begin
    if (!aresetn || set_default) begin
      state_r <= ST_IDLE;
      amp_meas_req <= 1'b0;
      phase_meas_req <= 1'b0;
      result_r <= `RST_BYTE;
      avg_r <= `RST_BYTE;
    end else begin
      amp_meas_req <= 1'b0;
      phase_meas_req <= expiry && ctrl_r[`CTRL_PHASE_BIT];
      case (state_r)
        ST_IDLE: begin
          // an expiry while a measurement is pending is dropped, one result per request
          if (expiry && ctrl_r[`CTRL_AMP_BIT]) begin
            amp_meas_req <= 1'b1;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (amp_meas_done) begin
            result_r <= amp_meas_result;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (avg_upd) begin
        avg_r <= avg_sum[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------
  wire stat_wr = wr_lane0 && (wr_idx == `IDX_IRQ_STATUS);
  wire [2:0] stat_clr = stat_wr ? wdata_r[2:0] : 3'h0;
  wire [2:0] stat_set;
  assign stat_set[`STAT_TIMEOUT_BIT] = expiry && ctrl_r[`CTRL_TIMEOUT_IRQ_BIT];
  assign stat_set[`STAT_AMP_BIT] = amp_event;
  assign stat_set[`STAT_PHASE_BIT] = phase_wake_event;

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= `RST_STAT;
      irq <= 1'b0;
    end else begin
      status_r <= (status_r & ~stat_clr) | stat_set;
      irq <= |(((status_r & ~stat_clr) | stat_set) & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [7:0] rd_idx = reg_index(s_axi_araddr);
  reg [7:0] rd_byte;

  always @* begin
    case (rd_idx)
      `IDX_WAKEUP_CTRL: rd_byte = ctrl_r;
      `IDX_AMP_CFG: rd_byte = cfg_r;
      `IDX_AMP_REF: rd_byte = ref_r;
      `IDX_AMP_AVG: rd_byte = avg_r;
      `IDX_AMP_RESULT: rd_byte = result_r;
      `IDX_IRQ_STATUS: rd_byte = {5'h0, status_r};
      `IDX_IRQ_MASK: rd_byte = {5'h0, mask_r};
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, rd_byte};
        s_axi_rresp <= mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* wakeup_timer_amplitude_detect_bench.sv */
// self-checking bench for the wake-up timer with amplitude detection
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_amp_regs.vh"
`define BA(i) {2'b00, i, 2'b00}
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module wakeup_timer_amplitude_detect_bench;
  // ----------------------------------------------------------------
  // short steps keep the run brief; periods scale from them
  // ----------------------------------------------------------------
  localparam int LS = 20;
  localparam int SS = 5;
  localparam logic [11:0] CTL = `BA(`IDX_WAKEUP_CTRL), CFG = `BA(`IDX_AMP_CFG), REF = `BA(`IDX_AMP_REF);
  localparam logic [11:0] AVG = `BA(`IDX_AMP_AVG), RES = `BA(`IDX_AMP_RESULT), STA = `BA(`IDX_IRQ_STATUS);
  localparam logic [11:0] MSK = `BA(`IDX_IRQ_MASK), CMD = `BA(`IDX_COMMAND);
  logic [11:0] zr [5] = '{CTL, CFG, REF, AVG, RES};
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, done = 0, pwe = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [7:0] mres = 0, mval = 0;
  logic [2:0] pend = 0;
  wire awr, wrd, bv, arr, rv, amq, phq, irq;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  int n_errors = 0, n_checks = 0, cyc = 0;
  wakeup_amp_timer #(.STEP_LONG_CYC(LS), .STEP_SHORT_CYC(SS), .ADDR_W(12)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .amp_meas_req(amq), .amp_meas_done(done),
    .amp_meas_result(mres), .phase_meas_req(phq), .phase_wake_event(pwe), .irq(irq));
  initial forever #20 aclk = ~aclk;
  // result line toggles outside the done cycle so a stale value never looks valid
  always @(posedge aclk) begin
    if (amq) pend <= 3'd3;
    else if (pend != 3'd0) pend <= pend - 3'd1;
    done <= (pend == 3'd1) && !amq;
    mres <= (pend == 3'd1) ? mval : ~mres;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // bus and measurement tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = `RESP_OKAY);
    @(posedge aclk);
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv && bre) break;
      if (bv) bre <= 1'b1;
    end
    bre <= 1'b0;
    `CHK("bresp", er, br)
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er = `RESP_OKAY);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv && rre) break;
      if (rv) rre <= 1'b1;
    end
    rre <= 1'b0;
    `CHK("rdata", {24'h000000, ed}, rdat)
    `CHK("rresp", er, rr)
  endtask
  task automatic meas(input logic [7:0] v);
    mval <= v;
    wr(CTL, 8'h04);
    for (int i = 0; i < 200 && !done; i++) @(posedge aclk);
    `CHK("meas done", 1'b1, done)
    wr(CTL, 8'h00);
  endtask
  task automatic per(input int e);
    int n = 0;
    for (int i = 0; i < 400 && !phq; i++) @(posedge aclk);
    do begin
      @(posedge aclk);
      n++;
    end while (!phq && n < 400);
    `CHK("period", e, n)
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (zr[i]) rd(zr[i], 8'h00);
    wr(CFG, 8'h40);
    wr(REF, 8'h80);
    meas(8'h84);
    rd(RES, 8'h84);
    rd(STA, 8'h00);
    meas(8'h7B);
    rd(RES, 8'h7B);
    rd(STA, 8'h02);
    for (int w = 0; w < 4; w++) begin
      wr(CMD, 8'h01);
      wr(CFG, {4'hF, 1'b1, w[1:0], 1'b1});
      meas(8'h80);
      rd(AVG, 8'h80 >> (w + 2));
    end
    wr(CMD, 8'h01);
    wr(CFG, 8'hF1);
    meas(8'h80);
    rd(AVG, 8'h00);
    meas(8'h0A);
    rd(AVG, 8'h02);
    meas(8'h00);
    rd(AVG, 8'h01);
    // a software reference far from the average must not be used while the average is selected
    wr(STA, 8'h02);
    wr(REF, 8'h80);
    meas(8'h05);
    rd(STA, 8'h00);
    rd(AVG, 8'h02);
    wr(CTL, 8'hF1);
    rd(CTL, 8'hF0);
    wr(CFG, 8'h5A);
    rd(CFG, 8'h5A);
    wr(REF, 8'hA5);
    rd(REF, 8'hA5);
    rd(12'h0C0, 8'h00, `RESP_SLVERR);
    wr(12'h0C0, 8'h11, `RESP_SLVERR);
    wr(CMD, 8'h01);
    foreach (zr[i]) rd(zr[i], 8'h00);
    wr(STA, 8'h07);
    for (int c = 0; c < 8; c++) begin
      wr(CTL, {1'b1, c[2:0], 4'hA});
      per((c + 1) * SS);
    end
    wr(CTL, 8'h0A);
    per(LS);
    wr(CTL, 8'h7A);
    per(8 * LS);
    wr(CTL, 8'h00);
    rd(STA, 8'h01);
    `CHK("irq masked", 1'b0, irq)
    wr(MSK, 8'h01);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    wr(STA, 8'h01);
    repeat (2) @(posedge aclk);
    `CHK("irq clear", 1'b0, irq)
    pwe <= 1'b1;
    @(posedge aclk);
    pwe <= 1'b0;
    rd(STA, 8'h04);
    wr(MSK, 8'h04);
    repeat (2) @(posedge aclk);
    `CHK("irq phase", 1'b1, irq)
    report_and_stop();
  end
endmodule
`default_nettype wire
